// file: axil_reg_port.sv
`timescale 1ns/1ns
`default_nettype none
module axil_reg_port #(
    parameter int AW = exec_pkg::AXI_AW
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic wr_en,
    output logic [AW-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_hit,
    output logic [AW-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_hit
);
    import exec_pkg::*;
    typedef struct packed {
        logic awready, wready, bvalid, arready, rvalid, wr_en;
        logic aw_full, w_full, rd_pend;
        logic [1:0] bresp, rresp;
        logic [AW-1:0] wr_addr, rd_addr;
        logic [31:0] wr_data, rdata;
        logic [3:0] wr_strb;
    } port_t;
    port_t s, next_s;

    // Address and data are held separately so either may come first.
    always_comb begin
        next_s = s;
        next_s.wr_en = 1'b0;
        if (awvalid && s.awready) begin
            next_s.aw_full = 1'b1;
            next_s.wr_addr = awaddr;
        end
        if (wvalid && s.wready) begin
            next_s.w_full = 1'b1;
            next_s.wr_data = wdata;
            next_s.wr_strb = wstrb;
        end
        if (s.aw_full && s.w_full && !s.bvalid) begin
            next_s.wr_en = 1'b1;
            next_s.aw_full = 1'b0;
            next_s.w_full = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        next_s.awready = !next_s.aw_full && !next_s.bvalid;
        next_s.wready = !next_s.w_full && !next_s.bvalid;
        if (arvalid && s.arready) begin
            next_s.rd_addr = araddr;
            next_s.rd_pend = 1'b1;
        end
        if (s.rd_pend) begin
            next_s.rd_pend = 1'b0;
            next_s.rvalid = 1'b1;
            next_s.rdata = rd_data;
            next_s.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        next_s.arready = !next_s.rd_pend && !next_s.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign awready = s.awready;
    assign wready = s.wready;
    assign bresp = s.bresp;
    assign bvalid = s.bvalid;
    assign arready = s.arready;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign rvalid = s.rvalid;
    assign wr_en = s.wr_en;
    assign wr_addr = s.wr_addr;
    assign wr_data = s.wr_data;
    assign wr_strb = s.wr_strb;
    assign rd_addr = s.rd_addr;
endmodule // axil_reg_port
`default_nettype wire

// file: bit_branch_call_clear_exec_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    n_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module bit_branch_call_clear_exec_bench;
    import exec_pkg::*;
    localparam int N = 44;
    localparam int K = 2 * N + 20;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [AXI_AW-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd, seed = 32'h0000_dd16;
    logic [3:0] wstrb, m_bk, m_bs;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid;
    logic arready, rvalid, rready, data_we, stack_push, mon;
    logic [1:0] bresp, rresp, resp, phase, last, m_nop;
    logic [PC_W-1:0] prog_addr, stack_data, m_pc, pushed;
    logic [15:0] prog_data, m_ir, pm [256];
    logic [DADDR_W-1:0] data_addr;
    logic [7:0] data_rd_data, data_wr_data, m_st, m_wk, m_ws, m_ss;
    logic [7:0] dm [4096];
    logic [19:0] wq [$];
    logic [19:0] wexp;
    int n_errors, n_checks, steps;
    always #10 aclk = ~aclk;
    bit_branch_exec i_bit_branch_exec (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .prog_addr,
        .prog_data, .data_addr, .data_rd_data, .data_wr_data, .data_we,
        .stack_push, .stack_data, .phase
    );
    exec_mem_model i_exec_mem_model (
        .aclk, .prog_addr, .prog_data, .data_addr, .data_rd_data,
        .data_wr_data, .data_we, .stack_push, .stack_data
    );
    function logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    task end_of_test;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task axi_wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 200 && !(bvalid && bready); i++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        resp = bresp;
        bready <= 1'b0;
        if (i == 200) begin n_errors++; end_of_test(); end
    endtask
    task axi_rd(input logic [7:0] a);
        int i;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 200 && !(rvalid && rready); i++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        if (i == 200) begin n_errors++; end_of_test(); end
    endtask
    // Flow only runs forward, so every run ends in the self loop at N+2.
    task load_prog;
        int i, t;
        logic [31:0] r;
        for (i = 0; i < 256; i++) pm[i] = 16'h0000;
        for (i = 0; i < N; i++) begin
            r = rnd();
            case (r % 7)
                0: pm[i] = {OP_SKIP_CLEAR, r[19:8]};
                1: pm[i] = {OP_TOGGLE, r[19:8]};
                2: pm[i] = {OP_BR_OVF, 8'(r[31:8] % (N - i))};
                3: pm[i] = {OP_BR_ZERO, 8'(r[31:8] % (N - i))};
                4: if (i < N - 2) begin
                    t = i + 2 + r[31:8] % (N - i - 1);
                    pm[i] = {OP_CALL, r[3], t[7:0]};
                    i++;
                    pm[i] = {4'hf, r[31:20]};
                end
                5: pm[i] = {OP_CLEAR, r[16:8]};
                default: pm[i] = {4'hf, r[19:8]};
            endcase
        end
        pm[N + 1] = {OP_CLEAR, 9'h000};
        pm[N + 2] = {OP_BR_ZERO, 8'hff};
        for (i = 0; i < 256; i++) i_exec_mem_model.prog[i] = pm[i];
        for (i = 0; i < 4096; i++) begin
            r = rnd();
            dm[i] = r[7:0];
            i_exec_mem_model.dmem[i] = r[7:0];
        end
    endtask
    task step_model;
        logic [15:0] f;
        logic [PC_W-1:0] npc;
        logic [1:0] nn;
        logic [DADDR_W-1:0] fa;
        logic [3:0] bank;
        f = pm[m_pc[8:1]];
        npc = m_pc + PC_STEP;
        nn = NOPS_NONE;
        bank = m_ir[7:0] < ACCESS_SPLIT ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK;
        fa = {m_ir[ACCESS_SEL_BIT] ? m_bk : bank, m_ir[7:0]};
        if (m_nop != NOPS_NONE) begin
            nn = m_nop - 2'h1;
        end else if (m_ir[15:12] == OP_SKIP_CLEAR) begin
            if (!dm[fa][m_ir[11:9]]) nn = (f[15:9] == OP_CALL ||
                f[15:8] == OP_GOTO || f[15:12] == OP_MOVE_FF) ? NOPS_TWO
                : NOPS_ONE;
        end else if (m_ir[15:12] == OP_TOGGLE) begin
            dm[fa][m_ir[11:9]] = ~dm[fa][m_ir[11:9]];
            wq.push_back({fa, dm[fa]});
        end else if ((m_ir[15:8] == OP_BR_OVF && m_st[FLAG_OVF]) ||
            (m_ir[15:8] == OP_BR_ZERO && m_st[FLAG_ZERO])) begin
            npc = m_pc + {{12{m_ir[7]}}, m_ir[7:0], 1'b0};
            nn = NOPS_ONE;
        end else if (m_ir[15:9] == OP_CALL) begin
            pushed = i_exec_mem_model.ret_stack.pop_front();
            `CHK("return address", m_pc + PC_STEP, pushed)
            if (m_ir[CALL_SHADOW_BIT]) begin
                m_ws = m_wk;
                m_ss = m_st;
                m_bs = m_bk;
            end
            npc = {f[11:0], m_ir[7:0], 1'b0};
            nn = NOPS_ONE;
        end else if (m_ir[15:9] == OP_CLEAR) begin
            dm[fa] = CLEAR_VALUE;
            wq.push_back({fa, CLEAR_VALUE});
            m_st[FLAG_ZERO] = 1'b1;
        end
        m_ir = f;
        m_pc = npc;
        m_nop = nn;
    endtask
    always @(posedge aclk) begin
        if (mon && stack_push) `CHK("push phase", 2'h3, phase)
        if (mon && last == 2'h3 && phase == 2'h0) begin
            step_model();
            steps++;
            `CHK("pc", m_pc, prog_addr)
        end
        if (mon && data_we) begin
            wexp = wq.pop_front();
            `CHK("write phase", 2'h0, phase)
            `CHK("write", wexp, {data_addr, data_wr_data})
        end
        last = phase;
    end
    initial begin
        logic [31:0] r;
        {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
        {arvalid, rready, mon, last, m_ws, m_ss, m_bs} = '0;
        wstrb = 4'hf;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(8'h40);
        `CHK("unmapped read", {RESP_SLVERR, 32'h0000_0000}, {resp, rd})
        axi_wr(REG_IR, 32'h0000_1234);
        `CHK("read-only write", RESP_SLVERR, resp)
        axi_wr(REG_PC, 32'h0000_0123);
        axi_rd(REG_PC);
        `CHK("pc write", 32'h0000_0122, rd)
        for (int run = 0; run < 4; run++) begin
            mon <= 1'b0;
            axi_wr(REG_CTRL, 32'h0000_0000);
            load_prog();
            r = rnd();
            {m_bk, m_wk, m_st} = r[19:0];
            axi_wr(REG_STATUS, {24'h00_0000, m_st});
            axi_wr(REG_WORK, {24'h00_0000, m_wk});
            axi_wr(REG_BANK, {28'h000_0000, m_bk});
            axi_wr(REG_PC, 32'h0000_0000);
            {m_pc, m_ir, m_nop, steps} = '0;
            wq.delete();
            i_exec_mem_model.ret_stack.delete();
            mon <= 1'b1;
            axi_wr(REG_CTRL, 32'h0000_0001);
            for (int i = 0; i < 4000 && steps < K; i++) @(posedge aclk);
            if (steps < K) begin n_errors++; end_of_test(); end
            axi_rd(REG_STATUS);
            `CHK("status", m_st, rd[7:0])
            axi_rd(REG_SHADOW);
            `CHK("shadows", {m_bs, m_ss, m_ws}, rd[19:0])
            `CHK("writes left", 0, wq.size())
        end
        end_of_test();
    end
endmodule // bit_branch_call_clear_exec_bench
`default_nettype wire

// file: bit_branch_exec.sv
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module bit_branch_exec (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [exec_pkg::AXI_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [exec_pkg::AXI_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic [exec_pkg::PC_W-1:0] prog_addr,
    input wire logic [15:0] prog_data,
    output logic [exec_pkg::DADDR_W-1:0] data_addr,
    input wire logic [7:0] data_rd_data,
    output logic [7:0] data_wr_data,
    output logic data_we,
    output logic stack_push,
    output logic [exec_pkg::PC_W-1:0] stack_data,
    output logic [1:0] phase
);
    import exec_pkg::*;
    typedef struct packed {
        phase_t q;
        logic run;
        logic [15:0] ir;
        logic [1:0] nop_cnt;
        logic [PC_W-1:0] pc;
        logic [DADDR_W-1:0] daddr;
        logic [7:0] opnd;
        logic [7:0] wr_data;
        logic we;
        logic push;
        logic [PC_W-1:0] push_pc;
        logic [7:0] working_register, status, ws, ss;
        logic [3:0] bank_select_register, bs;
    } core_t;
    core_t s, next_s;

    logic wr_en, wr_hit, rd_hit;
    logic [AXI_AW-1:0] wr_addr, rd_addr;
    logic [31:0] wr_data, rd_data, wm;
    logic [3:0] wr_strb;
    logic act, is_skip, is_tog, is_bov, is_bz, is_call, is_clr, file_op;
    logic taken, bit_clear;
    logic [7:0] bmask;
    logic [DADDR_W-1:0] faddr;
    logic [PC_W-1:0] br_target, call_target;

    function automatic logic two_word(input logic [15:0] w);
        return w[15:9] == OP_CALL || w[15:8] == OP_GOTO ||
            w[15:12] == OP_MOVE_FF;
    endfunction

    axil_reg_port #(.AW(AXI_AW)) bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_hit(wr_hit),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_hit(rd_hit)
    );

    // A lone 1111 word matches none of these and so runs as a no-operation.
    always_comb begin
        act = s.run && (s.nop_cnt == NOPS_NONE);
        is_skip = s.ir[15:12] == OP_SKIP_CLEAR;
        is_tog = s.ir[15:12] == OP_TOGGLE;
        is_bov = s.ir[15:8] == OP_BR_OVF;
        is_bz = s.ir[15:8] == OP_BR_ZERO;
        is_call = s.ir[15:9] == OP_CALL;
        is_clr = s.ir[15:9] == OP_CLEAR;
        file_op = is_skip || is_tog || is_clr;
        bmask = 8'h01 << s.ir[11:9];
        bit_clear = (s.opnd & bmask) == 8'h00;
        if (s.ir[ACCESS_SEL_BIT]) begin
            faddr = {s.bank_select_register, s.ir[7:0]};
        end else if (s.ir[7:0] < ACCESS_SPLIT) begin
            faddr = {ACCESS_LOW_BANK, s.ir[7:0]};
        end else begin
            faddr = {ACCESS_HIGH_BANK, s.ir[7:0]};
        end
        taken = (is_bov && s.status[FLAG_OVF]) ||
            (is_bz && s.status[FLAG_ZERO]);
        br_target = s.pc + {{(PC_W-9){s.ir[7]}}, s.ir[7:0], 1'b0};
        call_target = {prog_data[11:0], s.ir[7:0], 1'b0};
        wm = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}},
            {8{wr_strb[0]}}};
    end

    always_comb begin
        next_s = s;
        next_s.we = 1'b0;
        next_s.push = 1'b0;
        if (wr_en) begin
            if (wr_addr == REG_CTRL) begin
                if (wm[CTRL_RUN_BIT]) begin
                    next_s.run = wr_data[CTRL_RUN_BIT];
                end
            end else if (wr_addr == REG_STATUS) begin
                next_s.status = (s.status & ~wm[7:0]) |
                    (wr_data[7:0] & wm[7:0]);
            end else if (wr_addr == REG_WORK) begin
                next_s.working_register = (s.working_register & ~wm[7:0]) | (wr_data[7:0] & wm[7:0]);
            end else if (wr_addr == REG_BANK) begin
                next_s.bank_select_register = (s.bank_select_register & ~wm[3:0]) | (wr_data[3:0] & wm[3:0]);
            end else if (wr_addr == REG_PC) begin
                next_s.pc = (s.pc & ~wm[PC_W-1:0]) |
                    (wr_data[PC_W-1:0] & wm[PC_W-1:0]);
                // Words sit on even addresses, so bit 0 always reads zero.
                next_s.pc[0] = 1'b0;
                // The word already fetched belongs to the old flow.
                next_s.nop_cnt = NOPS_ONE;
            end
        end
        // Hardware updates below override a software write in the same cycle.
        case (s.q)
            PH_DECODE: begin
                if (s.run) begin
                    next_s.q = PH_READ;
                end
                if (act && file_op) begin
                    next_s.daddr = faddr;
                end
            end
            PH_READ: begin
                if (s.run) begin
                    next_s.q = PH_PROCESS;
                end
                next_s.opnd = data_rd_data;
            end
            PH_PROCESS: begin
                if (s.run) begin
                    next_s.q = PH_WRITE;
                end
                if (act && is_call) begin
                    next_s.push = 1'b1;
                    next_s.push_pc = s.pc + PC_STEP;
                end
            end
            PH_WRITE: begin
                if (s.run) begin
                    next_s.q = PH_DECODE;
                    next_s.ir = prog_data;
                    next_s.pc = s.pc + PC_STEP;
                    next_s.nop_cnt = (s.nop_cnt != NOPS_NONE) ?
                        s.nop_cnt - NOPS_ONE : NOPS_NONE;
                end
                if (act) begin
                    if (is_skip && bit_clear) begin
                        next_s.nop_cnt = two_word(prog_data) ?
                            NOPS_TWO : NOPS_ONE;
                    end
                    if (is_tog) begin
                        next_s.wr_data = s.opnd ^ bmask;
                        next_s.we = 1'b1;
                    end
                    if (is_clr) begin
                        next_s.wr_data = CLEAR_VALUE;
                        next_s.we = 1'b1;
                        next_s.status[FLAG_ZERO] = 1'b1;
                    end
                    if (taken) begin
                        next_s.pc = br_target;
                        next_s.nop_cnt = NOPS_ONE;
                    end
                    if (is_call) begin
                        next_s.pc = call_target;
                        next_s.nop_cnt = NOPS_ONE;
                        if (s.ir[CALL_SHADOW_BIT]) begin
                            next_s.ws = s.working_register;
                            next_s.ss = s.status;
                            next_s.bs = s.bank_select_register;
                        end
                    end
                end
            end
            default: begin
                next_s.q = PH_DECODE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b1;
        if (rd_addr == REG_CTRL) begin
            rd_data[CTRL_RUN_BIT] = s.run;
        end else if (rd_addr == REG_STATUS) begin
            rd_data[7:0] = s.status;
        end else if (rd_addr == REG_WORK) begin
            rd_data[7:0] = s.working_register;
        end else if (rd_addr == REG_BANK) begin
            rd_data[3:0] = s.bank_select_register;
        end else if (rd_addr == REG_PC) begin
            rd_data[PC_W-1:0] = s.pc;
        end else if (rd_addr == REG_SHADOW) begin
            rd_data[19:0] = {s.bs, s.ss, s.ws};
        end else if (rd_addr == REG_IR) begin
            rd_data[19:0] = {s.nop_cnt, s.q, s.ir};
        end else begin
            rd_hit = 1'b0;
        end
        wr_hit = wr_addr == REG_CTRL || wr_addr == REG_STATUS ||
            wr_addr == REG_WORK || wr_addr == REG_BANK || wr_addr == REG_PC;
    end

    assign prog_addr = s.pc;
    assign data_addr = s.daddr;
    assign data_wr_data = s.wr_data;
    assign data_we = s.we;
    assign stack_push = s.push;
    assign stack_data = s.push_pc;
    assign phase = s.q;

    a_skip_discard: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s.q == PH_WRITE && act && is_skip && bit_clear |=>
        s.nop_cnt != NOPS_NONE && !data_we && s.status == $past(s.status))
        else $error("skip did not squash the next word");

    a_skip_two_word: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s.q == PH_WRITE && act && is_skip && bit_clear &&
        two_word(prog_data) |=> s.nop_cnt == 2'h2)
        else $error("skip over two-word instruction lacks two nops");

    a_access_bank: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s.q == PH_DECODE && act && file_op |=>
        s.daddr[11:8] == ($past(s.ir[8]) ? $past(s.bank_select_register) :
        ($past(s.ir[7]) ? 4'hf : 4'h0)) && s.daddr[7:0] == $past(s.ir[7:0]))
        else $error("file address bank wrong");

    a_toggle_write: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s.q == PH_WRITE && act && is_tog |=> data_we &&
        (data_wr_data ^ $past(s.opnd)) == (8'h01 << $past(s.ir[11:9]))
        ##1 !data_we)
        else $error("toggle wrote wrong value");

    a_bov_taken: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s.q == PH_WRITE && act && is_bov |=>
        s.pc == ($past(s.status[3]) ? $past(br_target) :
        $past(s.pc) + 21'h0_0002))
        else $error("overflow branch target wrong");

    a_bz_flags: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s.q == PH_WRITE && act && is_bz &&
        !(wr_en && wr_addr == REG_STATUS) |=> s.status == $past(s.status))
        else $error("zero branch changed flags");

    a_not_taken: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s.q == PH_WRITE && act && is_bz && !s.status[2] |=>
        s.nop_cnt == 2'h0 && s.pc == $past(s.pc) + 21'h0_0002)
        else $error("untaken branch cost a cycle");

    a_call_target: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s.q == PH_WRITE && act && is_call |=> s.nop_cnt == 2'h1 &&
        s.pc == {$past(prog_data[11:0]), $past(s.ir[7:0]), 1'b0})
        else $error("call target wrong");

    a_call_push: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s.q == PH_PROCESS && act && is_call |=> stack_push &&
        stack_data == $past(s.pc) + 21'h0_0002 ##1 !stack_push)
        else $error("call push wrong");

    a_call_shadow: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s.q == PH_WRITE && act && is_call |=>
        ($past(s.ir[8]) ? s.ws == $past(s.working_register) && s.bs == $past(s.bank_select_register) &&
        s.ss == $past(s.status) :
        s.ws == $past(s.ws) && s.ss == $past(s.ss) && s.bs == $past(s.bs)))
        else $error("shadow update wrong");

    a_clear_zero: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s.q == PH_WRITE && act && is_clr |=>
        data_we && data_wr_data == 8'h00 && s.status[2])
        else $error("clear did not write zero and set zero flag");
endmodule // bit_branch_exec
`default_nettype wire

// file: exec_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module exec_mem_model (
    input wire logic aclk,
    input wire logic [exec_pkg::PC_W-1:0] prog_addr,
    output logic [15:0] prog_data,
    input wire logic [exec_pkg::DADDR_W-1:0] data_addr,
    output logic [7:0] data_rd_data,
    input wire logic [7:0] data_wr_data,
    input wire logic data_we,
    input wire logic stack_push,
    input wire logic [exec_pkg::PC_W-1:0] stack_data
);
    import exec_pkg::*;
    // Only the low address bits select a word, so program addresses alias.
    // The bench relies on that to reach call targets with high bits set.
    logic [15:0] prog [256];
    logic [7:0] dmem [4096];
    logic [PC_W-1:0] ret_stack [$];
    assign prog_data = prog[prog_addr[8:1]];
    assign data_rd_data = dmem[data_addr];
    always @(posedge aclk) begin
        if (data_we) begin
            dmem[data_addr] <= data_wr_data;
        end
        if (stack_push) begin
            ret_stack.push_back(stack_data);
        end
    end
endmodule // exec_mem_model
`default_nettype wire

// file: exec_pkg.sv
// Functional notes
// - A word with top nibble 1011 is bit test skip if clear, carrying a 3-bit bit index, the access select bit and an 8-bit file address.
// - When the tested bit is zero the prefetched word is discarded and a no-operation runs in its place, taking two cycles with no flag change.
// - When the discarded word starts a two-word instruction, the skip takes three cycles with two full no-operation cycles.
// - File instructions use the access bank when the access bit is 0 and the bank select register when it is 1.
// - A word with top nibble 0111 toggles the chosen bit of the file register in one cycle, read in the second phase and written in the fourth.
// - Upper byte 1110 0100 is branch on overflow with a signed 8-bit offset, taken only when the overflow flag is set.
// - Upper byte 1110 0000 is branch on zero with a signed 8-bit offset, taken only when the zero flag is set, leaving all flags alone.
// - A taken branch loads the incremented program counter plus twice the offset in the fourth phase and adds one no-operation cycle; not taken costs one cycle.
// - The call is two words: 1110 110 with the shadow bit and target bits 7 to 0, then 1111 with target bits 19 to 8.
// - A call pushes the address after the two-word call and loads the 20-bit target into program counter bits 20 to 1.
// - With the shadow bit set a call copies working, status and bank select registers into their shadows, otherwise the shadows keep their value.
// - A call takes two cycles: decode and low byte, push in the third phase, high bits and counter write in the fourth, then a no-operation cycle.
// - Upper bits 0110 101 clear the addressed file register and set the zero flag in one cycle.
`default_nettype none
package exec_pkg;
    localparam int AXI_AW = 8;
    localparam int PC_W = 21;
    localparam int DADDR_W = 12;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
    localparam logic [AXI_AW-1:0] REG_STATUS = 8'h04;
    localparam logic [AXI_AW-1:0] REG_WORK = 8'h08;
    localparam logic [AXI_AW-1:0] REG_BANK = 8'h0c;
    localparam logic [AXI_AW-1:0] REG_PC = 8'h10;
    localparam logic [AXI_AW-1:0] REG_SHADOW = 8'h14;
    localparam logic [AXI_AW-1:0] REG_IR = 8'h18;
    localparam int CTRL_RUN_BIT = 0;
    localparam int FLAG_ZERO = 2;
    localparam int FLAG_OVF = 3;
    localparam int CALL_SHADOW_BIT = 8;
    localparam int ACCESS_SEL_BIT = 8;
    localparam logic [3:0] OP_SKIP_CLEAR = 4'hb;
    localparam logic [3:0] OP_TOGGLE = 4'h7;
    localparam logic [7:0] OP_BR_OVF = 8'he4;
    localparam logic [7:0] OP_BR_ZERO = 8'he0;
    localparam logic [6:0] OP_CALL = 7'h76;
    localparam logic [6:0] OP_CLEAR = 7'h35;
    localparam logic [7:0] OP_GOTO = 8'hef;
    localparam logic [3:0] OP_MOVE_FF = 4'hc;
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    localparam logic [7:0] CLEAR_VALUE = 8'h00;
    localparam logic [PC_W-1:0] PC_STEP = 21'h0_0002;
    localparam logic [1:0] NOPS_NONE = 2'h0;
    localparam logic [1:0] NOPS_ONE = 2'h1;
    localparam logic [1:0] NOPS_TWO = 2'h2;
    typedef enum logic [1:0] {
        PH_DECODE,
        PH_READ,
        PH_PROCESS,
        PH_WRITE
    } phase_t;
endpackage
`default_nettype wire
